// ---- design/flash_cmd_pkg.sv ----
package flash_cmd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] STATUS_OFFSET = 8'h00;
    localparam logic [7:0] MASK_OFFSET = 8'h04;
    localparam logic [7:0] INDEX_OFFSET = 8'h08;
    localparam logic [7:0] PARAM_OFFSET = 8'h0c;
    localparam logic [7:0] SECURITY_OFFSET = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // Status field positions (mask register shares them)
    localparam int DONE_BIT = 7;
    localparam int ACC_ERR_BIT = 5;
    localparam int PROT_ERR_BIT = 4;
    localparam int VERR_BIT = 1;
    localparam int VUNC_BIT = 0;
    localparam logic [7:0] STATUS_W1C = 8'hb0;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Security register field positions
    localparam int SEC_SECURED_BIT = 0;
    localparam int SEC_LOCKOUT_BIT = 1;
    localparam int SEC_KEY_EN_LSB = 2;

    ////////////////////////////////////////////////////////////////////////
    // Commands and their parameter word index at launch
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h0a;
    localparam logic [7:0] CMD_UNSECURE = 8'h0b;
    localparam logic [7:0] CMD_BACKDOOR_KEY = 8'h0c;
    localparam logic [2:0] IDX_SECTOR_ERASE = 3'h1;
    localparam logic [2:0] IDX_UNSECURE = 3'h0;
    localparam logic [2:0] IDX_BACKDOOR_KEY = 3'h4;
    localparam logic [2:0] IDX_RESET = 3'h0;
    localparam logic [2:0] IDX_LAST_WORD = 3'h4;
    localparam logic [1:0] KEY_ENABLED = 2'h2;

    // Commands allowed per mode: bit0 sector erase, bit1 unsecure, bit2 key
    localparam logic [2:0] ALLOW_NORMAL = 3'h5;
    localparam logic [2:0] ALLOW_SPECIAL = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Program flash map: 128 KB at the top of the global space
    localparam logic [23:0] PFLASH_BASE = 24'hfe0000;
    localparam int SECTOR_LSB = 9;
    localparam int NUM_SECTORS = 256;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_ERASE = 2'b10,
        ST_FINISH = 2'b11
    } seq_state_t;

endpackage : flash_cmd_pkg

// ---- design/axil_reg_port.sv ----
`timescale 1ns/10ps
module axil_reg_port (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    logic wr_take;
    logic rd_take;

    // Address and data are taken together, so no half-write is stored
    assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        && !s_axi_awready;
    assign rd_take = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    assign wr_en = wr_take;
    assign wr_addr = s_axi_awaddr;
    assign wr_data = s_axi_wdata;
    assign wr_strb = s_axi_wstrb;
    assign rd_addr = s_axi_araddr;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= flash_cmd_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= wr_take;
            s_axi_wready <= wr_take;
            if (wr_take) begin
                s_axi_bresp <= wr_err ? flash_cmd_pkg::RESP_SLVERR
                    : flash_cmd_pkg::RESP_OKAY;
            end
            // Response only after the address and data handshake edge
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= flash_cmd_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= rd_take;
            if (rd_take) begin
                s_axi_rdata <= rd_err ? 32'h0 : rd_data;
                s_axi_rresp <= rd_err ? flash_cmd_pkg::RESP_SLVERR
                    : flash_cmd_pkg::RESP_OKAY;
            end
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : axil_reg_port

// ---- design/flash_cmd_seq.sv ----
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module flash_cmd_seq (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic special_mode,
    input wire logic secure_at_reset,
    input wire logic [1:0] backdoor_key_enable_field,
    input wire logic [63:0] stored_key,
    input wire logic [255:0] protected_sectors,
    input wire logic eeprom_any_protected,
    output logic array_erase_req,
    output logic array_erase_all,
    output logic [23:0] array_erase_addr,
    input wire logic array_done,
    input wire logic array_verify_err,
    input wire logic array_verify_uncorr,
    output logic secured,
    output logic irq
);

    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    logic [7:0] flash_status_reg;
    logic [7:0] mask_reg;
    logic [2:0] param_word_index;
    logic [15:0] command_param_words [0:4];
    logic secure_reg;
    logic lockout_reg;
    flash_cmd_pkg::seq_state_t state_reg;

    logic launch;
    logic set_done;
    logic set_access_error_flag;
    logic set_protection_violation_flag;
    logic set_verr;
    logic set_vunc;
    logic release_sec;
    logic key_fail;
    logic start_erase;
    logic erase_all_next;

    logic [7:0] cmd_code;
    logic [23:0] glob_addr;
    logic [2:0] allow_mask;
    logic mode_ok;
    logic addr_valid;
    logic addr_aligned;
    logic [7:0] sector_sel;
    logic any_pflash_prot;
    logic [63:0] key_supplied;

    ////////////////////////////////////////////////////////////////////////
    axil_reg_port u_port (
        .sys_clk(sys_clk),
        .reset(reset),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    always_comb begin
        unique case (wr_addr)
            flash_cmd_pkg::STATUS_OFFSET,
            flash_cmd_pkg::MASK_OFFSET,
            flash_cmd_pkg::INDEX_OFFSET,
            flash_cmd_pkg::PARAM_OFFSET,
            flash_cmd_pkg::SECURITY_OFFSET: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    always_comb begin
        rd_err = 1'b0;
        rd_data = 32'h0;
        unique case (rd_addr)
            flash_cmd_pkg::STATUS_OFFSET: rd_data = {24'h0, flash_status_reg};
            flash_cmd_pkg::MASK_OFFSET: rd_data = {24'h0, mask_reg};
            flash_cmd_pkg::INDEX_OFFSET: rd_data = {29'h0, param_word_index};
            flash_cmd_pkg::PARAM_OFFSET: begin
                if (param_word_index <= flash_cmd_pkg::IDX_LAST_WORD) begin
                    rd_data = {16'h0, command_param_words[param_word_index]};
                end
            end
            flash_cmd_pkg::SECURITY_OFFSET: begin
                rd_data = {28'h0, backdoor_key_enable_field, lockout_reg,
                    secure_reg};
            end
            default: rd_err = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Software writes; parameter words are frozen while a command runs
    // Writing one to the complete flag while it is set launches
    assign launch = wr_en && wr_strb[0]
        && (wr_addr == flash_cmd_pkg::STATUS_OFFSET)
        && wr_data[flash_cmd_pkg::DONE_BIT]
        && flash_status_reg[flash_cmd_pkg::DONE_BIT];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask_reg <= flash_cmd_pkg::MASK_RESET;
        end else if (wr_en && wr_strb[0]
                && wr_addr == flash_cmd_pkg::MASK_OFFSET) begin
            mask_reg <= wr_data[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            param_word_index <= flash_cmd_pkg::IDX_RESET;
        end else if (wr_en && wr_strb[0]
                && wr_addr == flash_cmd_pkg::INDEX_OFFSET
                && flash_status_reg[flash_cmd_pkg::DONE_BIT]) begin
            param_word_index <= wr_data[2:0];
        end
    end

    generate
        for (genvar w = 0; w < 5; w++) begin : g_word
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    command_param_words[w] <= 16'h0;
                end else if (wr_en && wr_addr == flash_cmd_pkg::PARAM_OFFSET
                        && flash_status_reg[flash_cmd_pkg::DONE_BIT]
                        && param_word_index == 3'(w)) begin
                    if (wr_strb[0]) begin
                        command_param_words[w][7:0] <= wr_data[7:0];
                    end
                    if (wr_strb[1]) begin
                        command_param_words[w][15:8] <= wr_data[15:8];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Command decode and checks
    assign cmd_code = command_param_words[0][15:8];
    assign glob_addr = {command_param_words[0][7:0], command_param_words[1]};
    assign allow_mask = special_mode ? flash_cmd_pkg::ALLOW_SPECIAL
        : flash_cmd_pkg::ALLOW_NORMAL;
    assign addr_valid = glob_addr >= flash_cmd_pkg::PFLASH_BASE;
    assign addr_aligned = glob_addr[2:0] == 3'h0;
    assign sector_sel = glob_addr[flash_cmd_pkg::SECTOR_LSB +: 8];
    assign any_pflash_prot = |protected_sectors;
    assign key_supplied = {command_param_words[4], command_param_words[3],
        command_param_words[2], command_param_words[1]};

    always_comb begin
        unique case (cmd_code)
            flash_cmd_pkg::CMD_SECTOR_ERASE: mode_ok = allow_mask[0];
            flash_cmd_pkg::CMD_UNSECURE: mode_ok = allow_mask[1];
            flash_cmd_pkg::CMD_BACKDOOR_KEY: mode_ok = allow_mask[2];
            default: mode_ok = 1'b0;
        endcase
    end

    // One cycle of checks; only a clean erase reaches the array
    always_comb begin
        set_access_error_flag = 1'b0;
        set_protection_violation_flag = 1'b0;
        start_erase = 1'b0;
        erase_all_next = 1'b0;
        release_sec = 1'b0;
        key_fail = 1'b0;
        if (state_reg == flash_cmd_pkg::ST_CHECK) begin
            unique case (cmd_code)
                flash_cmd_pkg::CMD_SECTOR_ERASE: begin
                    if (param_word_index != flash_cmd_pkg::IDX_SECTOR_ERASE
                            || !mode_ok || !addr_valid || !addr_aligned) begin
                        set_access_error_flag = 1'b1;
                    end else if (protected_sectors[sector_sel]) begin
                        set_protection_violation_flag = 1'b1;
                    end else begin
                        start_erase = 1'b1;
                    end
                end
                flash_cmd_pkg::CMD_UNSECURE: begin
                    if (param_word_index != flash_cmd_pkg::IDX_UNSECURE
                            || !mode_ok) begin
                        set_access_error_flag = 1'b1;
                    end else if (any_pflash_prot || eeprom_any_protected) begin
                        set_protection_violation_flag = 1'b1;
                    end else begin
                        start_erase = 1'b1;
                        erase_all_next = 1'b1;
                    end
                end
                flash_cmd_pkg::CMD_BACKDOOR_KEY: begin
                    if (param_word_index != flash_cmd_pkg::IDX_BACKDOOR_KEY
                            || !mode_ok || lockout_reg
                            || backdoor_key_enable_field
                            != flash_cmd_pkg::KEY_ENABLED) begin
                        set_access_error_flag = 1'b1;
                    end else if (key_supplied == stored_key) begin
                        release_sec = 1'b1;
                    end else begin
                        set_access_error_flag = 1'b1;
                        key_fail = 1'b1;
                    end
                end
                default: set_access_error_flag = 1'b1;
            endcase
        end
    end

    assign set_verr = state_reg == flash_cmd_pkg::ST_ERASE && array_done
        && (array_verify_err || array_verify_uncorr);
    assign set_vunc = state_reg == flash_cmd_pkg::ST_ERASE && array_done
        && array_verify_uncorr;
    assign set_done = state_reg == flash_cmd_pkg::ST_FINISH;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= flash_cmd_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                flash_cmd_pkg::ST_IDLE: begin
                    if (launch) begin
                        state_reg <= flash_cmd_pkg::ST_CHECK;
                    end
                end
                flash_cmd_pkg::ST_CHECK: begin
                    state_reg <= start_erase ? flash_cmd_pkg::ST_ERASE
                        : flash_cmd_pkg::ST_FINISH;
                end
                flash_cmd_pkg::ST_ERASE: begin
                    if (array_done) begin
                        state_reg <= flash_cmd_pkg::ST_FINISH;
                    end
                end
                flash_cmd_pkg::ST_FINISH: begin
                    state_reg <= flash_cmd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Erase request holds until the array reports done
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            array_erase_req <= 1'b0;
            array_erase_all <= 1'b0;
            array_erase_addr <= 24'h0;
        end else if (start_erase) begin
            array_erase_req <= 1'b1;
            array_erase_all <= erase_all_next;
            array_erase_addr <= erase_all_next ? flash_cmd_pkg::PFLASH_BASE
                : {glob_addr[23:flash_cmd_pkg::SECTOR_LSB],
                   {flash_cmd_pkg::SECTOR_LSB{1'b0}}};
        end else if (array_done) begin
            array_erase_req <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status: access and protection error flags are write-one-to-clear, set wins;
    // launch clears everything so a new command starts clean
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flash_status_reg <= flash_cmd_pkg::STATUS_RESET;
        end else if (launch) begin
            flash_status_reg <= 8'h0;
        end else begin
            if (wr_en && wr_strb[0]
                    && wr_addr == flash_cmd_pkg::STATUS_OFFSET) begin
                flash_status_reg <= flash_status_reg
                    & ~(wr_data[7:0] & flash_cmd_pkg::STATUS_W1C
                    & ~(8'(1) << flash_cmd_pkg::DONE_BIT));
            end
            if (set_done) begin
                flash_status_reg[flash_cmd_pkg::DONE_BIT] <= 1'b1;
            end
            if (set_access_error_flag) begin
                flash_status_reg[flash_cmd_pkg::ACC_ERR_BIT] <= 1'b1;
            end
            if (set_protection_violation_flag) begin
                flash_status_reg[flash_cmd_pkg::PROT_ERR_BIT] <= 1'b1;
            end
            if (set_verr) begin
                flash_status_reg[flash_cmd_pkg::VERR_BIT] <= 1'b1;
            end
            if (set_vunc) begin
                flash_status_reg[flash_cmd_pkg::VUNC_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flash_status_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Security state is taken from the strap in the reset cycles
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            secure_reg <= secure_at_reset;
        end else if (release_sec) begin
            secure_reg <= 1'b0;
        end else if (state_reg == flash_cmd_pkg::ST_ERASE && array_done
                && array_erase_all && !array_verify_err
                && !array_verify_uncorr) begin
            secure_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lockout_reg <= 1'b0;
        end else if (key_fail) begin
            lockout_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            secured <= 1'b1;
        end else begin
            secured <= secure_reg;
        end
    end

endmodule : flash_cmd_seq

// ---- tb/flash_cmd_asserts.sv ----
`timescale 1ns/10ps
module flash_cmd_asserts (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic s_axi_awready,
    input wire logic special_mode,
    input wire logic [255:0] protected_sectors,
    input wire logic eeprom_any_protected,
    input wire logic array_erase_req,
    input wire logic array_erase_all,
    input wire logic [23:0] array_erase_addr,
    input wire logic array_done,
    input wire logic array_verify_err,
    input wire logic secured
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence erase_go;
        $rose(array_erase_req);
    endsequence
    sequence erase_end;
        array_erase_req && array_done;
    endsequence
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
    erase_hold_a: assert property (
        array_erase_req && !array_done |=> array_erase_req
        && $stable(array_erase_addr)) else $error("erase dropped");
    erase_stop_a: assert property (erase_end |=> !array_erase_req)
        else $error("erase not ended");
    sector_addr_a: assert property (
        array_erase_req && !array_erase_all |-> array_erase_addr[8:0] == 9'h0
        && array_erase_addr >= flash_cmd_pkg::PFLASH_BASE) else $error("addr");
    sector_prot_a: assert property (
        erase_go ##0 !array_erase_all
        |-> !protected_sectors[array_erase_addr[16:9]]) else $error("prot");
    all_allowed_a: assert property (
        erase_go ##0 array_erase_all |-> special_mode && !eeprom_any_protected
        && protected_sectors == '0) else $error("unsecure not allowed");
    fail_keeps_a: assert property (
        erase_end ##0 (array_erase_all && array_verify_err && secured)
        |=> secured [*3]) else $error("security lost");
    sector_sec_a: assert property (
        array_erase_req && !array_erase_all |=> $stable(secured))
        else $error("security moved");
endmodule : flash_cmd_asserts
bind flash_cmd_seq flash_cmd_asserts chk_i (
    .sys_clk(sys_clk), .reset(reset), .s_axi_awready(s_axi_awready),
    .special_mode(special_mode), .protected_sectors(protected_sectors),
    .eeprom_any_protected(eeprom_any_protected),
    .array_erase_req(array_erase_req), .array_erase_all(array_erase_all),
    .array_erase_addr(array_erase_addr), .array_done(array_done),
    .array_verify_err(array_verify_err), .secured(secured)
);

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    logic sys_clk = 1'b0, reset = 1'b1, e = 1'b0, u = 1'b0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rdata, rdv;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic awr, bv, arr, rv, secured, irq, ereq, eall, sp = 1'b0;
    logic done = 1'b0, ve = 1'b0, vu = 1'b0, eep = 1'b0;
    logic [1:0] bresp, rresp, resp, ken = 2'h2;
    logic [63:0] key;
    logic [255:0] prot = '0;
    logic [23:0] eaddr, a;
    logic [15:0] w [5] = '{default: 16'h0};
    logic [15:0] t0 [8] = '{16'h0afe, 16'h0afd, 16'h0afe, 16'h0afe,
        16'h0b00, 16'h0b00, 16'h0b00, 16'h0500};
    logic [15:0] t1 [8] = '{16'h0, 16'h0, 16'h4, 16'h600, 16'h0, 16'h0,
        16'h0, 16'h0};
    int tix [8] = '{2, 1, 1, 1, 0, 1, 0, 0};
    int seed = 32'h05c3cd63;
    int n_errors = 0;
    int checks = 0;
    flash_cmd_seq uut (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .special_mode(sp), .secure_at_reset(1'b1),
        .backdoor_key_enable_field(ken), .stored_key(key),
        .protected_sectors(prot), .eeprom_any_protected(eep),
        .array_erase_req(ereq), .array_erase_all(eall),
        .array_erase_addr(eaddr), .array_done(done), .array_verify_err(ve),
        .array_verify_uncorr(vu), .secured(secured), .irq(irq));
    always #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] ex, got);
        checks++;
        if (got !== ex) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic wt(ref logic s);
        repeat (100) begin
            @(posedge sys_clk);
            if (s === 1'b1) return;
        end
        chk("handshake", 32'h1, 32'h0);
    endtask : wt
    // Address and data go out together; both are taken on one edge
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        awa <= ad;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        wt(awr);
        awv <= 1'b0;
        wv <= 1'b0;
        if (bv !== 1'b1) wt(bv);
        resp = bresp;
        bry <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        @(posedge sys_clk);
        ara <= ad;
        arv <= 1'b1;
        rry <= 1'b1;
        wt(arr);
        arv <= 1'b0;
        if (rv !== 1'b1) wt(rv);
        rdv = rdata;
        resp = rresp;
        rry <= 1'b0;
    endtask : rd
    task automatic cmd(input int ix);
        for (int i = 0; i <= ix; i++) begin
            wr(8'h08, 32'(i));
            wr(8'h0c, {16'h0, w[i]});
        end
        wr(8'h00, 32'h80);
    endtask : cmd
    // Only reads while busy: index and parameter writes are ignored during an erase
    task automatic er(input logic [23:0] base, input logic ea);
        wt(ereq);
        chk("erase addr", 32'(base), 32'(eaddr));
        chk("erase all", 32'(ea), 32'(eall));
        rd(8'h00);
        chk("busy", 32'h0, 32'(rdv[7]));
        done <= 1'b1;
        ve <= e;
        vu <= u;
        @(posedge sys_clk);
        done <= 1'b0;
    endtask : er
    task automatic fin(input logic [7:0] ex, input string nm);
        repeat (40) begin
            rd(8'h00);
            if (rdv[7] === 1'b1) break;
        end
        chk(nm, 32'(ex), rdv);
    endtask : fin
    function automatic logic [7:0] vb(input logic fe, fu);
        return {6'h20, fe | fu, fu};
    endfunction : vb
    task automatic do_reset;
        reset <= 1'b1;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
    endtask : do_reset
    task automatic summarize;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        n_errors++;
        summarize;
    end
    initial begin
        key = {$random(seed), $random(seed)};
        do_reset;
        rd(8'h00);
        chk("status", 32'h80, rdv);
        rd(8'h10);
        chk("security", 32'h9, rdv);
        for (int k = 0; k < 4; k++) begin
            a = 24'hfe0000 | 24'($random(seed)) & 24'h01fff8;
            if (k == 0) a = 24'hfffff8;
            e = 1'($random(seed));
            u = 1'($random(seed));
            w[0] = {8'h0a, a[23:16]};
            w[1] = a[15:0];
            cmd(1);
            er({a[23:9], 9'h0}, 1'b0);
            fin(vb(e, u), "erase status");
            chk("irq masked", 32'h0, 32'(irq));
        end
        $display("done erase");
        wr(8'h04, 32'h30);
        for (int c = 0; c < 8; c++) begin
            w[0] = t0[c];
            w[1] = t1[c];
            prot[3] <= (c == 3);
            eep <= (c == 6);
            sp <= (c > 4);
            cmd(tix[c]);
            fin((c == 3 || c == 6) ? 8'h90 : 8'ha0, "error");
            chk("irq set", 32'h1, 32'(irq));
            wr(8'h00, 32'h30);
            rd(8'h00);
            chk("cleared", 32'h80, rdv);
            chk("irq clear", 32'h0, 32'(irq));
        end
        $display("done errors");
        w[0] = 16'h0b00;
        e = 1'b1;
        u = 1'b0;
        for (int k = 0; k < 2; k++) begin
            cmd(0);
            er(24'hfe0000, 1'b1);
            fin(vb(e, 1'b0), "unsecure");
            chk("secured", 32'(e), 32'(secured));
            e = 1'b0;
        end
        $display("done unsecure");
        sp <= 1'b0;
        w[0] = 16'h0c00;
        for (int i = 0; i < 4; i++) w[i + 1] = key[16 * i +: 16];
        for (int k = 0; k < 5; k++) begin
            if (k == 0 || k == 3) do_reset;
            ken <= (k == 0) ? 2'h1 : 2'h2;
            w[2][0] = w[2][0] ^ (k > 2);
            cmd((k == 1) ? 3 : 4);
            fin((k == 2) ? 8'h80 : 8'ha0, "key");
            chk("key sec", 32'(k != 2), 32'(secured));
        end
        rd(8'h10);
        chk("lockout", 32'hb, rdv);
        wr(8'h20, 32'h1);
        chk("bad write", 32'h2, 32'(resp));
        rd(8'h20);
        chk("bad read", 32'h2, 32'(resp));
        $display("done key");
        summarize;
    end
endmodule : testbench
